// ### pkg/sector_guard_pkg.sv
// package: constants and carriers for the sector write-protection block
package sector_guard_pkg;
   localparam int          UNIT_COUNT      = 286;
   localparam int          UNIT_W          = 9;
   localparam int          ADDR_W          = 24;
   localparam int          BLOCK_UNITS     = 254;  // 64 KB blocks 0..253
   localparam int          FIRST_SMALL_SEC = 4064; // first 4 KB sector
   localparam int          BLOCK_SHIFT     = 16;
   localparam int          SECTOR_SHIFT    = 12;
   localparam logic        PERSIST_RESET   = 1'b1; // erased = unprotected
   localparam logic        DYNAMIC_RESET   = 1'b1;
   // typical page program and sector erase times, in ns
   localparam int          PROG_TIME_NS    = 200000;
   localparam int          ERASE_TIME_NS   = 45000000;
   localparam int          CLK_PERIOD_NS   = 8;
   localparam int          PROG_CYCLES     = PROG_TIME_NS / CLK_PERIOD_NS;
   localparam int          ERASE_CYCLES    = ERASE_TIME_NS / CLK_PERIOD_NS;
   localparam int          CNT_W           = 24;

   typedef enum logic [2:0] {
      CMD_NONE, CMD_PERSIST_PROG, CMD_PERSIST_ERASE, CMD_PERSIST_READ,
      CMD_DYNAMIC_WRITE, CMD_LOCK_CLEAR, CMD_PASSWORD_OK, CMD_SOFT_RESET
   } cmd_e;

   typedef struct packed {
      cmd_e               op;
      logic [ADDR_W-1:0]  addr;
      logic               data;
   } cmd_s;

   typedef struct packed {
      logic               valid;
      logic               value;
      logic               fail;
   } reply_s;
endpackage : sector_guard_pkg

// ### src/sector_write_protection.sv
// sector write-protection: persistent and dynamic bits plus change lock
//
// Behaviour
// (R01) 254 blocks plus 32 top sectors mapped
// (R02) one persistent bit per protection unit
// (R03) program singly to 0, erase all to 1
// (R04) erase preprogram/verify handled internally
// (R05) busy flag reported during program or erase
// (R06) array reads refused while programming
// (R07) host reads with unit base address
// (R08) erase takes no address, hits all
// (R09) read command returns persistent bit
// (R10) persistent bits start erased (1)
// (R11) dynamic write: 0 protects, 1 unprotects
// (R12) persistent 0 protects regardless of dynamic
// (R13) lock 0 rejects persistent program/erase
// (R14) persistent mode: lock 1 at reset
// (R15) password mode: lock 0, password sets
// (R16) host clears lock after configuring bits
// (R17) dynamic bits default to 1
// (R18) lock clear command drives lock 0
// (R19) software reset leaves lock unchanged
`timescale 1ns/1ns
module sector_write_protection
   import sector_guard_pkg::*;
#(
   parameter int PROG_CNT  = PROG_CYCLES,
   parameter int ERASE_CNT = ERASE_CYCLES
)(
   input  wire logic                  i_clk_sys,
   input  wire logic                  i_resetn,
   input  wire logic                  i_password_mode,
   input  wire cmd_s                  i_cmd,
   input  wire logic [ADDR_W-1:0]     i_check_addr,
   input  wire logic                  i_array_read_req,
   output logic                       o_operation_pending_flag,
   output reply_s                     o_reply,
   output logic                       o_persist_change_lock,
   output logic                       o_check_protected,
   output logic                       o_array_read_grant
);

   typedef enum logic [1:0] {ST_IDLE, ST_PROG, ST_PRE, ST_ERASE} state_e;

   ////////////////////////////////////////////////////////////////////////
   // address to protection unit index
   // blocks below the top two map by 64 KB, the top 32 sectors by 4 KB
   function automatic logic [UNIT_W-1:0] unit_of(input logic [ADDR_W-1:0] a);
      logic [UNIT_W-1:0] blk;
      blk = UNIT_W'(a >> BLOCK_SHIFT);
      if (blk < UNIT_W'(BLOCK_UNITS))
         unit_of = blk; // [R01]
      else
         unit_of = UNIT_W'((a >> SECTOR_SHIFT) - FIRST_SMALL_SEC
                           + BLOCK_UNITS); // [R01]
   endfunction : unit_of

   // nonvolatile: the declaration value is the erased state as delivered
   logic [UNIT_COUNT-1:0] persist_q = {UNIT_COUNT{PERSIST_RESET}}; // [R10]
   logic [UNIT_COUNT-1:0] dynamic_q;
   logic                  lock_q;
   logic                  seen_reset_q;
   state_e                state_q;
   logic [CNT_W-1:0]      cnt_q;
   logic [UNIT_W-1:0]     prog_unit_q;
   logic                  pw_mode_s1_q;
   logic                  pw_mode_q;
   reply_s                reply_q;
   logic                  check_q;
   logic                  grant_q;
   logic                  busy_q;

   ////////////////////////////////////////////////////////////////////////
   // command decode
   wire logic [UNIT_W-1:0] cmd_unit   = unit_of(i_cmd.addr);
   wire logic [UNIT_W-1:0] check_unit = unit_of(i_check_addr);
   wire logic idle      = (state_q == ST_IDLE);
   wire logic want_prog = idle && i_cmd.op == CMD_PERSIST_PROG;
   wire logic want_ers  = idle && i_cmd.op == CMD_PERSIST_ERASE;
   wire logic go_prog   = want_prog && lock_q; // [R13]
   wire logic go_ers    = want_ers && lock_q;  // [R13] [R08]
   wire logic cnt_done  = (cnt_q == '0);
   // last count of each phase; only one phase can be live at a time
   wire logic prog_last  = (state_q == ST_PROG) && cnt_done;
   wire logic pre_last   = (state_q == ST_PRE) && cnt_done;
   wire logic erase_last = (state_q == ST_ERASE) && cnt_done;

   // strap sampling of the lock mode pin
   always_ff @(posedge i_clk_sys) begin
      pw_mode_s1_q <= i_password_mode;
      pw_mode_q    <= pw_mode_s1_q;
   end

   ////////////////////////////////////////////////////////////////////////
   // lock bit: set at hardware reset per mode, never by soft reset.
   // the mode comes from the synchronised strap; reset is held long
   // enough for it to settle, and the first edge after release loads
   // the mode's value. once cleared in persistent mode nothing but a
   // hardware reset brings it back [R14]
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         lock_q       <= 1'b0;
         seen_reset_q <= 1'b1;
      end else begin
         seen_reset_q <= 1'b0;
         if (seen_reset_q)
            lock_q <= !pw_mode_q; // [R14] [R15]
         else if (i_cmd.op == CMD_LOCK_CLEAR)
            lock_q <= 1'b0; // [R18]
         else if (i_cmd.op == CMD_PASSWORD_OK && pw_mode_q)
            lock_q <= 1'b1; // [R15]
      end // soft reset deliberately ignored here [R19]
   end

   ////////////////////////////////////////////////////////////////////////
   // program / erase sequencer
   // an erase first preprograms every bit, then erases them together;
   // the counters hold the phase lengths so the busy span is fixed.
   // program and erase commands that arrive while busy are ignored, not queued
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         state_q     <= ST_IDLE;
         cnt_q       <= '0;
         prog_unit_q <= '0;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (go_prog) begin
                  state_q     <= ST_PROG;
                  cnt_q       <= CNT_W'(PROG_CNT - 1);
                  prog_unit_q <= cmd_unit;
               end else if (go_ers) begin
                  state_q <= ST_PRE; // [R04]
                  cnt_q   <= CNT_W'(PROG_CNT - 1);
               end
            end
            ST_PROG: begin
               cnt_q <= cnt_q - 1'b1;
               if (cnt_done)
                  state_q <= ST_IDLE;
            end
            ST_PRE: begin
               cnt_q <= cnt_q - 1'b1;
               if (cnt_done) begin
                  state_q <= ST_ERASE;
                  cnt_q   <= CNT_W'(ERASE_CNT - 1);
               end
            end
            ST_ERASE: begin
               cnt_q <= cnt_q - 1'b1;
               if (cnt_done)
                  state_q <= ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // persistent bits: nonvolatile, so hardware reset leaves them alone.
   // one bit per unit [R02]; only the sequencer's last count writes, so a
   // refused (locked) command can never disturb them [R13]
   always_ff @(posedge i_clk_sys) begin
      if (prog_last)
         persist_q[prog_unit_q] <= 1'b0; // [R03]
      else if (pre_last)
         persist_q <= '0; // internal preprogram [R04]
      else if (erase_last)
         persist_q <= {UNIT_COUNT{PERSIST_RESET}}; // [R03] [R08]
   end

   ////////////////////////////////////////////////////////////////////////
   // dynamic bits, volatile
   // a soft reset command returns them to unprotected, like power-up
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn)
         dynamic_q <= {UNIT_COUNT{DYNAMIC_RESET}}; // [R17]
      else if (i_cmd.op == CMD_SOFT_RESET)
         dynamic_q <= {UNIT_COUNT{DYNAMIC_RESET}};
      else if (i_cmd.op == CMD_DYNAMIC_WRITE)
         dynamic_q[cmd_unit] <= i_cmd.data; // [R11]
   end

   ////////////////////////////////////////////////////////////////////////
   // busy flag: a register of its own so the pin comes from a flop; it
   // rises with an accepted program or erase and falls on the last count,
   // which keeps it equal to "sequencer not idle" cycle for cycle
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn)
         busy_q <= 1'b0;
      else if (go_prog || go_ers)
         busy_q <= 1'b1; // [R05]
      else if (prog_last || erase_last)
         busy_q <= 1'b0; // [R05]
   end

   ////////////////////////////////////////////////////////////////////////
   // replies, protection check and read gating
   // replies and the check are registered, so they lag one cycle
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         reply_q <= '0;
         check_q <= 1'b0;
         grant_q <= 1'b0;
      end else begin
         reply_q.valid <= (i_cmd.op == CMD_PERSIST_READ) && idle
                          || want_prog || want_ers;
         reply_q.value <= persist_q[cmd_unit]; // [R09] [R07]
         reply_q.fail  <= (want_prog || want_ers) && !lock_q; // [R13]
         check_q <= !(persist_q[check_unit]
                      && dynamic_q[check_unit]); // [R12]
         grant_q <= i_array_read_req && state_q != ST_PROG; // [R06]
      end
   end

   assign o_operation_pending_flag = busy_q; // [R05]
   assign o_reply               = reply_q;
   assign o_persist_change_lock = lock_q;
   assign o_check_protected     = check_q;
   assign o_array_read_grant    = grant_q;

endmodule : sector_write_protection

// ### bench/sector_write_protection_properties.sv
// checker: port timing of the sector write-protection block
`timescale 1ns/1ns
module sector_write_protection_properties
   import sector_guard_pkg::*;
#(parameter int PROG_CNT = 4, parameter int ERASE_CNT = 8)(
   input wire logic              i_clk_sys,
   input wire logic              i_resetn,
   input wire logic              i_password_mode,
   input wire cmd_s              i_cmd,
   input wire logic [ADDR_W-1:0] i_check_addr,
   input wire logic              i_array_read_req,
   input wire logic              o_operation_pending_flag,
   input wire reply_s            o_reply,
   input wire logic              o_persist_change_lock,
   input wire logic              o_check_protected,
   input wire logic              o_array_read_grant
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_resetn);
   // short names and accepted program or erase
   wire bz = o_operation_pending_flag;
   wire lk = o_persist_change_lock;
   wire pe = i_cmd.op == CMD_PERSIST_PROG || i_cmd.op == CMD_PERSIST_ERASE;
   sequence s_prog; i_cmd.op == CMD_PERSIST_PROG && lk && !bz; endsequence
   sequence s_erase; i_cmd.op == CMD_PERSIST_ERASE && lk && !bz; endsequence
   a_prog_span: assert property (s_prog |=> bz[*4] ##1 !bz)
      else $error("program busy span");
   a_erase_span:
      assert property (s_erase |=> bz[*6] ##1 bz[*6] ##1 !bz)
      else $error("erase busy span");
   a_read_hold:
      assert property (s_prog |=> ##1 (!o_array_read_grant)[*4])
      else $error("array read granted while programming");
   a_read_grant:
      assert property (i_array_read_req && !bz |=> o_array_read_grant)
      else $error("array read not granted");
   a_locked_fail:
      assert property (pe && !lk && !bz |=> o_reply.valid && o_reply.fail)
      else $error("locked change not failed");
   a_lock_stays:
      assert property (!lk && $past(i_resetn) && !i_password_mode |=> !lk)
      else $error("lock set again");
   a_reset_lock:
      assert property ($rose(i_resetn) |=> lk != i_password_mode)
      else $error("lock wrong after reset");
   a_lock_clear: assert property (i_cmd.op == CMD_LOCK_CLEAR |=> !lk)
      else $error("lock not cleared");
endmodule : sector_write_protection_properties

// ### bench/flash_host_model.sv
// host model: sends one protection command aligned to its unit base
`timescale 1ns/1ns
module flash_host_model
   import sector_guard_pkg::*;
(
   input  wire logic i_clk_sys,
   input  wire logic i_issue,
   input  wire cmd_s i_req,
   output cmd_s      o_cmd
);
   // top 4 KB sectors keep bits 23:12, blocks keep bits 23:16
   wire              small_sec = i_req.addr[23:17] == 7'h7f;
   wire [ADDR_W-1:0] unit_mask = small_sec ? 24'hfff000 : 24'hff0000;
   wire [ADDR_W-1:0] base      = i_req.addr & unit_mask;
   // one-cycle pulse, idle op otherwise
   always @(posedge i_clk_sys) begin
      if (i_issue)
         o_cmd <= '{i_req.op, base, i_req.data};
      else
         o_cmd <= '0;
   end
endmodule : flash_host_model

// ### bench/sector_write_protection_tb_top.sv
// testbench: protection commands in persistent and password modes
`timescale 1ns/1ns
module sector_write_protection_tb_top;
   import sector_guard_pkg::*;
   localparam int PROG_CNT  = 4;
   localparam int ERASE_CNT = 8;
   logic              i_clk_sys = 1'b0, i_resetn = 1'b0, issue = 1'b0;
   logic              i_password_mode = 1'b0, i_array_read_req = 1'b0;
   logic              o_operation_pending_flag, o_array_read_grant;
   logic              o_persist_change_lock, o_check_protected;
   logic [ADDR_W-1:0] i_check_addr = '0, a, s;
   cmd_s              i_cmd, req = '0;
   reply_s            o_reply;
   logic [3:0]        expq[$], ex; // reply, care value, value, fail
   int                errors = 0, tests_run = 0;
   always #4 i_clk_sys = ~i_clk_sys;
   sector_write_protection #(.PROG_CNT(PROG_CNT), .ERASE_CNT(ERASE_CNT))
      DUT (.*);
   flash_host_model host (.i_clk_sys(i_clk_sys), .i_issue(issue),
                          .i_req(req), .o_cmd(i_cmd));
   task automatic chk(string n, logic s_v, logic e_v);
      tests_run++;
      if (s_v !== e_v) errors++;
      if (s_v !== e_v) $display("MISMATCH %s exp %b seen %b", n, e_v, s_v);
   endtask : chk
   // one command, queried address follows it; waits out busy
   task automatic send(cmd_e op, logic [ADDR_W-1:0] ad, logic d,
                       logic [3:0] e);
      @(posedge i_clk_sys);
      req <= '{op, ad, d};
      issue <= 1'b1;
      i_check_addr <= ad;
      if (e[3]) expq.push_back(e);
      @(posedge i_clk_sys);
      issue <= 1'b0;
      repeat (3) @(posedge i_clk_sys);
      #1;
      for (int n = 0; n < 40 && o_operation_pending_flag !== 1'b0; n++) begin
         @(posedge i_clk_sys);
         #1;
      end
      chk("busy done", o_operation_pending_flag, 1'b0);
   endtask : send
   // replies matched in order against queued notes
   always @(negedge i_clk_sys) begin
      if (o_reply.valid === 1'b1) begin
         ex = (expq.size() > 0) ? expq.pop_front() : 4'h0;
         chk("reply expected", ex[3], 1'b1);
         chk("reply fail", o_reply.fail, ex[0]);
         if (ex[2]) chk("reply value", o_reply.value, ex[1]);
      end
   end
   task automatic close_out(int late);
      errors += late;
      chk("replies pending", expq.size() == 0, 1'b1);
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : close_out
   initial #24000 close_out(1);
   initial begin
      void'($urandom(28));
      a = {8'($urandom_range(253, 0)), 16'($urandom)};
      s = {12'hfe0 + 12'($urandom_range(31, 0)), 12'($urandom)};
      repeat (8) @(posedge i_clk_sys);
      i_resetn <= 1'b1;
      i_array_read_req <= 1'b1;
      send(CMD_PERSIST_READ, a, 1'b0, 4'he);
      chk("lock", o_persist_change_lock, 1'b1);
      chk("protected", o_check_protected, 1'b0);
      send(CMD_PERSIST_PROG, a, 1'b0, 4'h8);
      send(CMD_DYNAMIC_WRITE, a, 1'b1, 4'h0);
      chk("protected", o_check_protected, 1'b1);
      send(CMD_PERSIST_READ, a, 1'b0, 4'hc);
      send(CMD_PERSIST_READ, a ^ 24'h010000, 1'b0, 4'he);
      send(CMD_DYNAMIC_WRITE, s, 1'b0, 4'h0);
      chk("protected", o_check_protected, 1'b1);
      send(CMD_DYNAMIC_WRITE, s ^ 24'h001000, 1'b1, 4'h0);
      chk("protected", o_check_protected, 1'b0);
      send(CMD_PERSIST_ERASE, a, 1'b0, 4'h8);
      send(CMD_PERSIST_READ, a, 1'b0, 4'he);
      send(CMD_SOFT_RESET, a, 1'b0, 4'h0);
      chk("lock", o_persist_change_lock, 1'b1);
      send(CMD_LOCK_CLEAR, a, 1'b0, 4'h0);
      chk("lock", o_persist_change_lock, 1'b0);
      send(CMD_PERSIST_PROG, a, 1'b0, 4'h9);
      send(CMD_PASSWORD_OK, a, 1'b0, 4'h0);
      chk("lock", o_persist_change_lock, 1'b0);
      @(posedge i_clk_sys);
      i_resetn <= 1'b0;
      i_password_mode <= 1'b1;
      repeat (8) @(posedge i_clk_sys);
      i_resetn <= 1'b1;
      send(CMD_PERSIST_ERASE, s, 1'b0, 4'h9);
      send(CMD_PASSWORD_OK, a, 1'b0, 4'h0);
      chk("lock", o_persist_change_lock, 1'b1);
      close_out(0);
   end
endmodule : sector_write_protection_tb_top
bind sector_write_protection sector_write_protection_properties
   #(.PROG_CNT(PROG_CNT), .ERASE_CNT(ERASE_CNT)) u_props (.*);
